// file: rtl/sci_core.sv
// Asynchronous serial transmitter and receiver with status and control.
// Assumes a synchronous register master and an asynchronous rx_pin.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/10ps

module sci_core
   import sci_pkg::*;
#(
   parameter int BAUD_RESET = BAUD_RST
)(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [AW-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic rx_pin,
   output logic tx_pin_out,
   output logic tx_pin_oe,
   output logic tx_irq,
   output logic rx_irq,
   output logic err_irq
);

   if (BAUD_RESET < 0 || BAUD_RESET > 255) begin : g_chk
      $error("BAUD_RESET must fit in eight bits");
   end

   localparam sci_state_s ST_RST = '{
      tbe: 1'b1,
      tx_line: 1'b1,
      rx_s1: 1'b1,
      rx_s2: 1'b1,
      baud: 8'(BAUD_RESET),
      div: 8'(BAUD_RESET),
      tx_st: TX_IDLE,
      rx_st: RX_SEARCH,
      default: '0
   };

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic maj3(logic [2:0] v);
      return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   function automatic logic [3:0] char_len(logic nine);
      return nine ? LEN9 : LEN8;
   endfunction

   // Parity sits in the top character bit
   function automatic logic [8:0] with_parity(logic [8:0] d, logic nine, logic odd);
      logic [8:0] r;
      r = d;
      if (nine) begin
         r[8] = odd ^ (^d[7:0]);
      end else begin
         r[7] = odd ^ (^d[6:0]);
      end
      return r;
   endfunction

   sci_state_s s;
   sci_state_s n;
   logic on;
   logic inv;
   logic nine;
   logic tx_done;
   logic stby;
   logic [4:0] r;
   logic [2:0] v3;
   logic v;
   logic [8:0] d9;
   logic [8:0] tx_d9;
   logic [7:0] thr;
   logic fin;
   logic brk;
   logic accept;
   logic msb;

   assign on = s.ctrl1[C1_ON];
   assign inv = s.ctrl1[C1_INV];
   assign nine = s.ctrl1[C1_NINE];
   assign stby = s.ctrl2[C2_STBY];
   assign tx_done = !on || (s.tx_st == TX_IDLE && s.tbe && !s.idle_pend
                    && !s.ctrl2[C2_BRK]);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      n = s;
      r = s.rx_rt + 5'h01;
      v3 = {s.rx_smp[1:0], s.rx_s2};
      v = maj3(v3);
      d9 = nine ? s.rx_sh : {1'b0, s.rx_sh[8:1]};
      tx_d9 = {s.ctrl3[C3_T9], s.tx_data};
      if (s.ctrl1[C1_PAR]) begin
         tx_d9 = with_parity(tx_d9, nine, s.ctrl1[C1_ODD]);
      end
      thr = {char_len(nine), 4'h0};
      fin = 1'b0;
      brk = 1'b0;
      accept = 1'b0;
      msb = nine ? d9[8] : d9[7];

      // Pin synchroniser
      n.rx_s1 = rx_pin;
      n.rx_s2 = s.rx_s1;

      // Oversample tick, one cycle wide while the baud register is nonzero
      n.tick = 1'b0;
      if (!on) begin
         n.div = s.baud;
      end else if (s.div == 8'h00) begin
         n.div = s.baud;
         n.tick = 1'b1;
      end else begin
         n.div = s.div - 8'h01;
      end

      // Flag clears go first so a same-cycle set survives
      if (reg_rd) begin
         unique case (reg_addr)
            A_CTRL1: n.rdata = s.ctrl1;
            A_CTRL2: n.rdata = s.ctrl2;
            A_CTRL3: n.rdata = {s.rx_ninth, s.ctrl3[6:0]};
            A_STAT1: n.rdata = {s.tbe, tx_done, s.rx_full, s.quiet,
                                s.ovr, s.nf, s.fe, s.pe};
            A_STAT2: n.rdata = {6'h00, s.brk, s.rx_st != RX_SEARCH};
            A_DATA: n.rdata = s.rx_buf;
            A_BAUD: n.rdata = s.baud;
            default: n.rdata = 8'h00;
         endcase
         if (reg_addr == A_STAT1 || reg_addr == A_STAT2) begin
            n.armed = 1'b1;
         end
         if (reg_addr == A_DATA && s.armed) begin
            n.armed = 1'b0;
            n.rx_full = 1'b0;
            n.quiet = 1'b0;
            n.ovr = 1'b0;
            n.nf = 1'b0;
            n.fe = 1'b0;
            n.pe = 1'b0;
            n.brk = 1'b0;
         end
      end

      // ----------------------------------------
      // Transmitter
      // ----------------------------------------
      n.tx_on_d = s.ctrl2[C2_TXON];
      if (!on) begin
         n.tx_st = TX_IDLE;
         n.tbe = 1'b1;
         n.idle_pend = 1'b0;
      end else begin
         if (s.ctrl2[C2_TXON] && !s.tx_on_d) begin
            n.idle_pend = 1'b1;
         end
         if (s.tx_st == TX_SHIFT) begin
            if (s.tick) begin
               n.tx_rt = s.tx_rt + 4'h1;
               if (s.tx_rt == TX_LAST) begin
                  n.tx_sh = {1'b1, s.tx_sh[10:1]};
                  n.tx_bits = s.tx_bits - 4'h1;
                  if (s.tx_bits == 4'h1) begin
                     n.tx_st = TX_IDLE;
                  end
               end
            end
         end else if (s.ctrl2[C2_TXON]) begin
            n.tx_rt = 4'h0;
            n.tx_bits = char_len(nine);
            if (s.ctrl2[C2_BRK]) begin
               // Pending idle follows the last break as its trailing ones
               n.tx_st = TX_SHIFT;
               n.tx_sh = 11'h000;
               n.idle_pend = 1'b1;
            end else if (s.idle_pend) begin
               n.tx_st = TX_SHIFT;
               n.tx_sh = 11'h7FF;
               n.idle_pend = 1'b0;
            end else if (!s.tbe) begin
               n.tx_st = TX_SHIFT;
               n.tx_sh = nine ? {1'b1, tx_d9, 1'b0}
                              : {2'h3, tx_d9[7:0], 1'b0};
               n.tbe = 1'b1;
            end
         end
      end
      n.tx_line = ((s.tx_st == TX_SHIFT) ? s.tx_sh[0] : 1'b1) ^ inv;

      // ----------------------------------------
      // Receiver
      // ----------------------------------------
      if (!on || !s.ctrl2[C2_RXON]) begin
         n.rx_st = RX_SEARCH;
         n.rx_hist = 3'h0;
         n.q_cnt = 8'h00;
      end else if (s.tick) begin
         n.rx_hist = {s.rx_hist[1:0], s.rx_s2};
         n.rx_rt = (r == RT_BIT) ? 5'h00 : r;
         if (r == RT_S1 || r == RT_S2 || r == RT_S3 || r == RT_D1
             || r == RT_D2 || r == RT_D3) begin
            n.rx_smp = v3;
         end
         unique case (s.rx_st)
            RX_SEARCH: begin
               if (s.rx_hist == START_HIST && !s.rx_s2) begin
                  n.rx_st = RX_START;
                  n.rx_rt = 5'h01;
                  n.rx_nz = 1'b0;
                  n.rx_idx = 4'h0;
                  n.rx_sh = 9'h000;
                  n.rx_last = 1'b0;
                  n.rx_edge = 5'h00;
               end
            end
            RX_START: begin
               if (r == RT_S3) begin
                  if (v) begin
                     n.rx_st = RX_SEARCH;
                     n.rx_hist = 3'h0;
                     n.rx_rt = 5'h00;
                  end else if (v3 != 3'h0) begin
                     n.rx_nz = 1'b1;
                  end
               end
               if (r >= RT_D1 && r <= RT_D3 && s.rx_s2) begin
                  n.rx_nz = 1'b1;
               end
               if (r == RT_BIT) begin
                  n.rx_st = RX_BITS;
               end
            end
            RX_BITS: begin
               if (r < RT_D1 && s.rx_last && s.rx_hist[0] && !s.rx_s2) begin
                  n.rx_edge = r;
               end
               if (r == RT_D3) begin
                  if (v3 != 3'h0 && v3 != 3'h7) begin
                     n.rx_nz = 1'b1;
                  end
                  n.rx_last = v;
                  n.rx_edge = 5'h00;
                  // Only late edges are pulled in; early ones ride the margin
                  if (!v && s.rx_last && s.rx_edge != 5'h00) begin
                     n.rx_rt = RT_D3 + 5'h01 - s.rx_edge;
                  end
                  if (s.rx_idx == (nine ? DBITS9 : DBITS8)) begin
                     fin = 1'b1;
                     n.rx_st = RX_SEARCH;
                     n.rx_hist = 3'h0;
                  end else begin
                     n.rx_sh = {v, s.rx_sh[8:1]};
                     n.rx_idx = s.rx_idx + 4'h1;
                  end
               end
            end
            default: n.rx_st = RX_SEARCH;
         endcase

         // Quiet line counting in oversample ticks
         if (!s.rx_s2) begin
            n.q_cnt = 8'h00;
            n.q_arm = 1'b1;
         end else if (s.ctrl1[C1_QSTOP] && s.rx_st != RX_SEARCH) begin
            n.q_cnt = 8'h00;
         end else if (s.q_cnt != thr) begin
            n.q_cnt = s.q_cnt + 8'h01;
            if (n.q_cnt == thr && s.q_arm) begin
               n.q_arm = 1'b0;
               if (stby && !s.ctrl1[C1_ADDR]) begin
                  n.ctrl2[C2_STBY] = 1'b0;
               end else begin
                  n.quiet = 1'b1;
               end
            end
         end
      end

      // Character completion
      if (fin) begin
         brk = (s.rx_sh == 9'h000) && !v;
         accept = !stby || (s.ctrl1[C1_ADDR] && msb);
         if (stby && accept) begin
            n.ctrl2[C2_STBY] = 1'b0;
         end
         if (accept) begin
            if (s.rx_full) begin
               n.ovr = 1'b1;
            end else begin
               n.rx_buf = d9[7:0];
               n.rx_ninth = msb;
               n.rx_full = 1'b1;
               n.fe = n.fe | !v;
               n.nf = n.nf | n.rx_nz;
               n.pe = n.pe | (s.ctrl1[C1_PAR]
                      && with_parity(d9, nine, s.ctrl1[C1_ODD]) != d9);
               n.brk = n.brk | brk;
            end
         end
      end

      // Register writes; buffer writes only land while it is empty and the unit is on
      if (reg_wr) begin
         unique case (reg_addr)
            A_CTRL1: n.ctrl1 = reg_wdata;
            A_CTRL2: n.ctrl2 = reg_wdata;
            A_CTRL3: n.ctrl3 = reg_wdata & C3_WMASK;
            A_BAUD: n.baud = reg_wdata;
            A_DATA: begin
               if (s.tbe && on) begin
                  n.tx_data = reg_wdata;
                  n.tbe = 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= ST_RST;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign reg_rdata = s.rdata;
   assign tx_pin_out = s.tx_line;
   assign tx_pin_oe = on;
   assign tx_irq = on && ((s.tbe && s.ctrl2[C2_TIE])
                   || (tx_done && s.ctrl2[C2_TX_DONE_IRQ_EN]));
   assign rx_irq = !stby && ((s.rx_full && s.ctrl2[C2_RIE])
                   || (s.quiet && s.ctrl2[C2_QIE]));
   assign err_irq = (s.ovr && s.ctrl3[C3_OIE]) || (s.nf && s.ctrl3[C3_NIE])
                    || (s.fe && s.ctrl3[C3_FIE]) || (s.pe && s.ctrl3[C3_PIE]);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   a_break_load: assert property (
      (on && s.tx_st == TX_IDLE && s.ctrl2[C2_TXON] && s.ctrl2[C2_BRK])
      |=> (s.tx_st == TX_SHIFT && s.tx_sh == 11'h000 && s.idle_pend))
      else $error("break character not loaded");

   a_idle_level: assert property (
      (on && s.tx_st == TX_IDLE) |=> (tx_pin_out == !$past(inv)))
      else $error("idle level ignores polarity");

   a_empty_load: assert property (
      (on && s.tx_st == TX_IDLE && s.ctrl2[C2_TXON] && !s.ctrl2[C2_BRK]
       && !s.idle_pend && !s.tbe) |=> (s.tbe && s.tx_st == TX_SHIFT))
      else $error("buffer empty not set on load");

   a_done_empty: assert property (
      (on && tx_done) |-> (s.tbe && s.tx_st == TX_IDLE))
      else $error("done while still sending");

   a_break_flags: assert property (
      (fin && brk && accept && !s.rx_full)
      |=> (s.fe && s.rx_full && s.brk && s.rx_buf == 8'h00 && !s.rx_ninth))
      else $error("break flags wrong");

   a_start_reject: assert property (
      (s.tick && s.rx_st == RX_START && s.rx_rt == RT_S2 + 5'h01 && v)
      |=> (s.rx_st == RX_SEARCH))
      else $error("bad start bit accepted");

   a_overrun_keep: assert property (
      (fin && accept && s.rx_full && !(reg_rd && reg_addr == A_DATA))
      |=> (s.ovr && $stable(s.rx_buf)))
      else $error("overrun lost old data");

   a_unit_off: assert property (
      (!on && !(reg_wr && reg_addr == A_CTRL1 && reg_wdata[C1_ON]))
      |=> (!tx_pin_oe && !tx_irq && tx_done && s.tbe))
      else $error("unit off not released");

   a_standby_quiet: assert property (
      (fin && stby && !accept && !(reg_rd && reg_addr == A_DATA))
      |=> ($stable(s.rx_full) && $stable(s.rx_buf)))
      else $error("standby character reached the buffer");

   a_tick_width: assert property (
      (s.tick && s.baud != 8'h00 && on) |=> !s.tick)
      else $error("oversample tick too wide");

endmodule

// file: rtl/sci_pkg.sv
// Constants, state encodings and state record of the serial unit.
// Assumes one system clock; all control sits in the core's registers.
package sci_pkg;

   // ----------------------------------------
   // Register indices
   // ----------------------------------------
   localparam int AW = 3;
   localparam logic [2:0] A_CTRL1 = 3'h0;
   localparam logic [2:0] A_CTRL2 = 3'h1;
   localparam logic [2:0] A_CTRL3 = 3'h2;
   localparam logic [2:0] A_STAT1 = 3'h3;
   localparam logic [2:0] A_STAT2 = 3'h4;
   localparam logic [2:0] A_DATA = 3'h5;
   localparam logic [2:0] A_BAUD = 3'h6;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int C1_ON = 6;
   localparam int C1_INV = 5;
   localparam int C1_NINE = 4;
   localparam int C1_ADDR = 3;
   localparam int C1_QSTOP = 2;
   localparam int C1_PAR = 1;
   localparam int C1_ODD = 0;
   localparam int C2_TIE = 7;
   localparam int C2_TX_DONE_IRQ_EN = 6;
   localparam int C2_RIE = 5;
   localparam int C2_QIE = 4;
   localparam int C2_TXON = 3;
   localparam int C2_RXON = 2;
   localparam int C2_STBY = 1;
   localparam int C2_BRK = 0;
   localparam int C3_T9 = 6;
   localparam int C3_OIE = 3;
   localparam int C3_NIE = 2;
   localparam int C3_FIE = 1;
   localparam int C3_PIE = 0;
   localparam logic [7:0] C3_WMASK = 8'h4F;

   // ----------------------------------------
   // Reset values and timing counts
   // ----------------------------------------
   localparam int BAUD_RST = 12;
   localparam logic [4:0] RT_BIT = 5'h10;
   localparam logic [4:0] RT_S1 = 5'h03;
   localparam logic [4:0] RT_S2 = 5'h05;
   localparam logic [4:0] RT_S3 = 5'h07;
   localparam logic [4:0] RT_D1 = 5'h08;
   localparam logic [4:0] RT_D2 = 5'h09;
   localparam logic [4:0] RT_D3 = 5'h0A;
   localparam logic [3:0] TX_LAST = 4'hF;
   localparam logic [3:0] LEN8 = 4'hA;
   localparam logic [3:0] LEN9 = 4'hB;
   localparam logic [3:0] DBITS8 = 4'h8;
   localparam logic [3:0] DBITS9 = 4'h9;
   localparam logic [2:0] START_HIST = 3'h7;

   typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} sci_tx_e;
   typedef enum logic [1:0] {
      RX_SEARCH = 2'b00,
      RX_START = 2'b01,
      RX_BITS = 2'b10
   } sci_rx_e;

   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] ctrl3;
      logic [7:0] baud;
      logic [7:0] div;
      logic [7:0] rdata;
      logic [7:0] tx_data;
      logic [7:0] rx_buf;
      logic [7:0] q_cnt;
      logic tick;
      logic rx_s1;
      logic rx_s2;
      logic tbe;
      logic idle_pend;
      logic tx_on_d;
      logic tx_line;
      sci_tx_e tx_st;
      logic [10:0] tx_sh;
      logic [3:0] tx_bits;
      logic [3:0] tx_rt;
      sci_rx_e rx_st;
      logic [4:0] rx_rt;
      logic [4:0] rx_edge;
      logic [2:0] rx_hist;
      logic [2:0] rx_smp;
      logic [3:0] rx_idx;
      logic [8:0] rx_sh;
      logic rx_last;
      logic rx_nz;
      logic rx_ninth;
      logic rx_full;
      logic quiet;
      logic ovr;
      logic nf;
      logic fe;
      logic pe;
      logic brk;
      logic q_arm;
      logic armed;
   } sci_state_s;

endpackage

// file: tb/sci_peer.sv
// Remote serial peer: drives frames onto rx_pin and decodes tx_pin.
// Assumes the core's baud register holds 0, so one bit lasts 16 clocks.
`timescale 1ns/10ps
module sci_peer (
   input wire logic sys_clk,
   input wire logic tx_line,
   output logic rx_line
);
   localparam int BT = 16;

   // The line idles high between frames
   initial rx_line = 1'b1;

   // ----------------------------------------
   // Frame out, LSB first; stop level chosen by the caller
   // ----------------------------------------
   task automatic send(input logic [8:0] d, input int n, input logic stp);
      rx_line <= 1'b0;
      repeat (BT) @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
         rx_line <= d[i];
         repeat (BT) @(posedge sys_clk);
      end
      rx_line <= stp;
      repeat (BT) @(posedge sys_clk);
      // Two idle bits so the next start follows three ones when the stop bit is 1, two when it is 0
      rx_line <= 1'b1;
      repeat (2 * BT) @(posedge sys_clk);
   endtask

   // ----------------------------------------
   // Frame in: wait for start, sample mid-bit
   // ----------------------------------------
   task automatic recv(input logic inv, output logic [7:0] d, output logic stp,
                       output int w);
      w = 0;
      while ((tx_line ^ inv) !== 1'b0 && w < 2000) begin
         @(posedge sys_clk);
         w++;
      end
      repeat (BT / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BT) @(posedge sys_clk);
         d[i] = tx_line ^ inv;
      end
      repeat (BT) @(posedge sys_clk);
      stp = tx_line ^ inv;
   endtask
endmodule

// file: tb/tb_sci_core.sv
// Self-checking bench of the serial core, register port plus peer model.
// Assumes a 20 MHz clock and the baud register set to 0 during tests.
`timescale 1ns/10ps
module tb_sci_core
   import sci_pkg::*;
;
   logic sys_clk;
   logic reset_n = 1'b0;
   logic [AW-1:0] reg_addr = '0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic rx_pin;
   logic tx_pin_out;
   logic tx_pin_oe;
   logic tx_irq;
   logic rx_irq;
   logic err_irq;
   int num_errors = 0;
   int checks_done = 0;
   logic [7:0] v;
   logic [7:0] d;
   logic [7:0] got;
   logic [8:0] d9;
   logic stp;
   int w;
   int n;

   sci_core u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rx_pin(rx_pin), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
      .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));

   sci_peer u_peer (.sys_clk(sys_clk), .tx_line(tx_pin_out), .rx_line(rx_pin));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] dat);
      reg_addr <= a;
      reg_wdata <= dat;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      // One idle edge so back-to-back writes never drive the strobe twice in one step
      @(posedge sys_clk);
   endtask

   // Data stand from the cycle after the strobe until the next read, so sample there
   task automatic rd(input logic [2:0] a, output logic [7:0] dat);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      dat = reg_rdata;
   endtask

   function automatic logic [7:0] bit8(input logic b);
      return {7'h00, b};
   endfunction

   task automatic results;
      $display("checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Whole run needs well under 10000 cycles
   initial begin
      #(50 * 20000);
      num_errors++;
      $display("watchdog expired");
      results();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      void'($urandom(32'h7d8eea2b));
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      rd(A_BAUD, v);
      chk(v, 8'(BAUD_RST));
      rd(A_CTRL1, v);
      chk(v, 8'h00);
      rd(A_STAT1, v);
      chk(v & 8'h80, 8'h80);
      rd(3'h7, v);
      chk(v, 8'h00);
      chk(bit8(tx_pin_oe), 8'h00);
      $display("test reset done");

      wr(A_BAUD, 8'h00);
      wr(A_CTRL1, 8'h40);
      wr(A_CTRL2, 8'h6C);
      chk(bit8(tx_pin_oe), 8'h01);
      for (int k = 0; k < 2; k++) begin
         wr(A_CTRL1, k[0] ? 8'h60 : 8'h40);
         d = 8'($urandom);
         wr(A_DATA, d);
         rd(A_STAT1, v);
         chk(v & 8'h40, 8'h00);
         u_peer.recv(k[0], got, stp, w);
         chk(got, d);
         chk(bit8(stp), 8'h01);
         if (k == 0) chk(bit8(w > 140), 8'h01);
         repeat (40) @(posedge sys_clk);
         chk(bit8(tx_pin_out), bit8(~k[0]));
         chk(bit8(tx_irq), 8'h01);
      end
      wr(A_CTRL1, 8'h40);
      // Toggle tx_on right after the buffer empties: one idle character must follow
      d = 8'($urandom);
      wr(A_DATA, d);
      wr(A_CTRL2, 8'h64);
      wr(A_CTRL2, 8'h6C);
      wr(A_DATA, ~d);
      u_peer.recv(1'b0, got, stp, w);
      chk(got, d);
      u_peer.recv(1'b0, got, stp, w);
      chk(got, ~d);
      chk(bit8(w > 150), 8'h01);
      wr(A_CTRL3, 8'h02);
      $display("test transmit done");

      for (int k = 0; k < 8; k++) begin
         d = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
         u_peer.send({1'b0, d}, 8, 1'b1);
         chk(bit8(rx_irq), 8'h01);
         rd(A_CTRL3, v);
         chk(bit8(v[7]), bit8(d[7]));
         rd(A_STAT1, v);
         chk(v & 8'h2F, 8'h20);
         rd(A_DATA, v);
         chk(v, d);
         chk(bit8(rx_irq), 8'h00);
      end
      $display("test receive done");

      d = 8'($urandom);
      u_peer.send({1'b0, d}, 8, 1'b1);
      u_peer.send(9'h05A, 8, 1'b1);
      rd(A_STAT1, v);
      chk(v & 8'h28, 8'h28);
      rd(A_DATA, v);
      chk(v, d);
      u_peer.send(9'h0C3, 8, 1'b0);
      chk(bit8(err_irq), 8'h01);
      rd(A_STAT1, v);
      chk(v & 8'h22, 8'h22);
      rd(A_DATA, v);
      // Break right after a frame whose top bit was 1
      u_peer.send(9'h000, 8, 1'b0);
      rd(A_CTRL3, v);
      chk(v & 8'h80, 8'h00);
      rd(A_STAT2, v);
      chk(v & 8'h02, 8'h02);
      rd(A_STAT1, v);
      chk(v & 8'h22, 8'h22);
      rd(A_DATA, v);
      chk(v, 8'h00);
      repeat (200) @(posedge sys_clk);
      rd(A_STAT1, v);
      chk(v & 8'h10, 8'h10);
      $display("test errors done");

      for (int k = 0; k < 2; k++) begin
         wr(A_CTRL1, (k == 0) ? 8'h42 : 8'h43);
         d = 8'($urandom) & 8'h7F;
         // Same top bit: wrong for even parity, right for odd
         d[7] = ~(^d[6:0]);
         u_peer.send({1'b0, d}, 8, 1'b1);
         rd(A_STAT1, v);
         chk(v & 8'h01, (k == 0) ? 8'h01 : 8'h00);
         rd(A_DATA, v);
      end
      wr(A_CTRL1, 8'h50);
      d9 = 9'($urandom);
      u_peer.send(d9, 9, 1'b1);
      rd(A_CTRL3, v);
      chk(bit8(v[7]), bit8(d9[8]));
      rd(A_STAT1, v);
      rd(A_DATA, v);
      chk(v, d9[7:0]);
      $display("test parity done");

      wr(A_CTRL1, 8'h48);
      wr(A_CTRL2, 8'h26);
      u_peer.send(9'h012, 8, 1'b1);
      chk(bit8(rx_irq), 8'h00);
      rd(A_STAT1, v);
      chk(v & 8'h20, 8'h00);
      u_peer.send(9'h085, 8, 1'b1);
      rd(A_CTRL2, v);
      chk(v & 8'h02, 8'h00);
      rd(A_STAT1, v);
      chk(v & 8'h20, 8'h20);
      rd(A_DATA, v);
      chk(v, 8'h85);
      $display("test wake done");

      wr(A_CTRL2, 8'h08);
      repeat (200) @(posedge sys_clk);
      wr(A_CTRL2, 8'h09);
      n = 0;
      while (tx_pin_out !== 1'b0 && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      wr(A_CTRL2, 8'h08);
      n = 1;
      while (tx_pin_out === 1'b0 && n < 1000) begin
         @(posedge sys_clk);
         n++;
      end
      chk(bit8(n > 150 && n < 170), 8'h01);
      repeat (8) @(posedge sys_clk);
      chk(bit8(tx_pin_out), 8'h01);
      $display("test break done");

      wr(A_CTRL1, 8'h00);
      @(posedge sys_clk);
      chk(bit8(tx_pin_oe), 8'h00);
      rd(A_STAT1, v);
      chk(v & 8'hC0, 8'hC0);
      $display("test disable done");
      results();
   end
endmodule
